// file: scpm_pkg.sv
// package for the system clock and power mode controller
// assumes a single 100 MHz clock domain for the register port and control logic
package scpm_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] ADDR_STATUS  = 4'h0;
	localparam logic [3:0] ADDR_SYSCLK  = 4'h1;
	localparam logic [3:0] ADDR_FASTOSC = 4'h2;
	localparam logic [3:0] ADDR_MODE    = 4'h3;
	// status field positions
	localparam int BIT_TIMEOUT   = 5;
	localparam int BIT_POWERDOWN = 4;
	// sysclk control field positions
	localparam int BIT_SEL_LO    = 5;
	localparam int BIT_FAST_KEEP = 1;
	localparam int BIT_SLOW_KEEP = 0;
	// fast osc control field positions
	localparam int BIT_STABLE    = 1;
	localparam int BIT_ENABLE    = 0;
	// reset values, and the select code of the sub clock
	localparam logic [2:0] SEL_RESET     = 3'h0;
	localparam logic [2:0] SEL_SUB       = 3'h7;
	localparam logic       FAST_EN_RESET = 1'b1;
	localparam logic [5:0] LOW_RESET     = 6'h00;
	// oscillator figures, kHz
	localparam int FAST_OSC_KHZ = 8000;
	localparam int SLOW_OSC_KHZ = 32;
	localparam int CLK_KHZ      = 100000;
	// fast oscillator settle time in us, least time rounded up
	localparam int FAST_SETTLE_US     = 16;
	localparam int FAST_SETTLE_CYCLES = (FAST_SETTLE_US * CLK_KHZ + 999) / 1000;
	// operating modes
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_SLOW,
		MODE_SLEEP,
		MODE_IDLE_SUB,
		MODE_IDLE_BOTH,
		MODE_IDLE_FAST
	} scpm_mode_t;
endpackage : scpm_pkg

// file: scpm_ctrl.sv
// system clock select, fast oscillator control, halt modes and status flags
// assumes oscillator ticks arrive asynchronously as toggling levels on pins
`timescale 1ns/1ns
`default_nettype none

module scpm_ctrl
	import scpm_pkg::*;
#(
	parameter int SETTLE_CYCLES = FAST_SETTLE_CYCLES
) (
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic       i_halt,
	input  wire logic       i_wdt_clear,
	input  wire logic       i_wdt_timeout,
	input  wire logic       i_wdt_enable,
	input  wire logic       i_wake,
	input  wire logic       i_fast_tick,
	input  wire logic       i_slow_tick,
	output logic [7:0]      o_rdata,
	output logic            o_fast_osc_en,
	output logic            o_slow_osc_en,
	output logic            o_fast_clk_en,
	output logic            o_sub_clk_en,
	output logic            o_sys_clk_en,
	output logic            o_cpu_run,
	output logic            o_sys_src_sub,
	output logic [2:0]      o_fast_div_sel,
	output logic            o_wdt_clk_en,
	output logic            o_tb_clk_en,
	output logic [2:0]      o_mode
);
	// elaboration check, the settle counter is 16 bits
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_settle_chk
		$error("settle cycles out of range");
	end

	// three-stage sync, an edge is seen when second and third differ
	logic [2:0] fast_sync;
	logic [2:0] slow_sync;
	logic       fast_seen;
	logic       slow_seen;
	logic [7:0] fast_idle_cnt;
	logic [7:0] slow_idle_cnt;
	logic       fast_running;
	logic       slow_running;

	// register state
	logic [2:0]  sysclk_select;
	logic        fast_osc_idle_keep;
	logic        slow_osc_idle_keep;
	logic        fast_osc_enable;
	logic        fast_osc_stable_flag;
	logic [15:0] settle_cnt;
	logic        watchdog_timeout_flag;
	logic        powerdown_flag;
	scpm_mode_t  mode;
	logic [2:0]  active_sel;
	logic [7:0]  rdata;

	logic [2:0]  next_sysclk_select;
	logic        next_fast_osc_idle_keep;
	logic        next_slow_osc_idle_keep;
	logic        next_fast_osc_enable;
	logic        next_fast_osc_stable_flag;
	logic [15:0] next_settle_cnt;
	logic        next_watchdog_timeout_flag;
	logic        next_powerdown_flag;
	scpm_mode_t  next_mode;
	logic [2:0]  next_active_sel;
	logic [7:0]  next_rdata;
	logic [7:0]  next_fast_idle_cnt;
	logic [7:0]  next_slow_idle_cnt;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			fast_sync <= 3'h0;
			slow_sync <= 3'h0;
		end else begin
			fast_sync <= {fast_sync[1:0], i_fast_tick};
			slow_sync <= {slow_sync[1:0], i_slow_tick};
		end
	end
	assign fast_seen = fast_sync[2] ^ fast_sync[1];
	assign slow_seen = slow_sync[2] ^ slow_sync[1];
	// an oscillator is deemed running while edges keep arriving
	always_comb begin
		next_fast_idle_cnt = fast_seen ? 8'h00 :
			(fast_idle_cnt == 8'hff ? fast_idle_cnt : fast_idle_cnt + 8'h01);
		next_slow_idle_cnt = slow_seen ? 8'h00 :
			(slow_idle_cnt == 8'hff ? slow_idle_cnt : slow_idle_cnt + 8'h01);
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			fast_idle_cnt <= 8'hff;
			slow_idle_cnt <= 8'hff;
		end else begin
			fast_idle_cnt <= next_fast_idle_cnt;
			slow_idle_cnt <= next_slow_idle_cnt;
		end
	end
	// slow osc period is about 3100 cycles, so idle counter only saturates
	assign fast_running = (fast_idle_cnt != 8'hff);
	assign slow_running = slow_running_f(slow_idle_cnt);
	function automatic logic slow_running_f(input logic [7:0] cnt);
		slow_running_f = (cnt != 8'hff) || slow_sync[2];
	endfunction : slow_running_f
	function automatic logic is_write(input logic [3:0] a);
		is_write = i_wr && (i_addr == a);
	endfunction : is_write

	always_comb begin
		next_sysclk_select        = sysclk_select;
		next_fast_osc_idle_keep   = fast_osc_idle_keep;
		next_slow_osc_idle_keep   = slow_osc_idle_keep;
		next_fast_osc_enable      = fast_osc_enable;
		next_fast_osc_stable_flag = fast_osc_stable_flag;
		next_settle_cnt           = settle_cnt;
		next_watchdog_timeout_flag = watchdog_timeout_flag;
		next_powerdown_flag       = powerdown_flag;
		next_mode                 = mode;
		next_active_sel           = active_sel;
		next_rdata                = 8'h00;
		if (is_write(ADDR_SYSCLK)) begin
			next_sysclk_select      = i_wdata[BIT_SEL_LO +: 3];
			next_fast_osc_idle_keep = i_wdata[BIT_FAST_KEEP];
			next_slow_osc_idle_keep = i_wdata[BIT_SLOW_KEEP];
		end
		if (is_write(ADDR_FASTOSC)) begin
			next_fast_osc_enable = i_wdata[BIT_ENABLE];
			if (i_wdata[BIT_ENABLE] && !fast_osc_enable) begin
				next_fast_osc_stable_flag = 1'b0;
				next_settle_cnt = 16'(SETTLE_CYCLES);
			end else if (!i_wdata[BIT_ENABLE]) begin
				next_fast_osc_stable_flag = 1'b0;
			end
		end else if (fast_osc_enable && !fast_osc_stable_flag && fast_running) begin
			if (settle_cnt <= 16'h0001) begin
				next_fast_osc_stable_flag = 1'b1;
			end else begin
				next_settle_cnt = settle_cnt - 16'h0001;
			end
		end
		if (i_wdt_clear || i_halt) begin
			next_watchdog_timeout_flag = 1'b0;
		end
		if (i_wdt_timeout) begin
			next_watchdog_timeout_flag = 1'b1;
		end
		if (i_wdt_clear) begin
			next_powerdown_flag = 1'b0;
		end
		if (i_halt) begin
			next_powerdown_flag = 1'b1;
		end
		// change over only on running source
		if (sysclk_select != active_sel) begin
			if (sysclk_select == SEL_SUB ? slow_running
				: (fast_running && fast_osc_stable_flag)) begin
				next_active_sel = sysclk_select;
			end
		end
		case (mode)
			MODE_NORMAL, MODE_SLOW: begin
				if (i_halt) begin
					case ({fast_osc_idle_keep, slow_osc_idle_keep})
						2'b00:   next_mode = MODE_SLEEP;
						2'b01:   next_mode = MODE_IDLE_SUB;
						2'b11:   next_mode = MODE_IDLE_BOTH;
						default: next_mode = MODE_IDLE_FAST;
					endcase
				end else begin
					next_mode = (active_sel == SEL_SUB) ? MODE_SLOW : MODE_NORMAL;
				end
			end
			MODE_SLEEP, MODE_IDLE_SUB, MODE_IDLE_BOTH, MODE_IDLE_FAST: begin
				if (i_wake) begin
					next_mode = (active_sel == SEL_SUB) ? MODE_SLOW : MODE_NORMAL;
				end
			end
			default: next_mode = MODE_NORMAL;
		endcase
		if (i_rd) begin
			case (i_addr)
				ADDR_STATUS: begin
					next_rdata[BIT_TIMEOUT]   = watchdog_timeout_flag;
					next_rdata[BIT_POWERDOWN] = powerdown_flag;
				end
				ADDR_SYSCLK: begin
					next_rdata[BIT_SEL_LO +: 3]  = sysclk_select;
					next_rdata[BIT_FAST_KEEP]    = fast_osc_idle_keep;
					next_rdata[BIT_SLOW_KEEP]    = slow_osc_idle_keep;
				end
				ADDR_FASTOSC: begin
					next_rdata[BIT_STABLE] = fast_osc_stable_flag;
					next_rdata[BIT_ENABLE] = fast_osc_enable;
				end
				ADDR_MODE: next_rdata = {5'h00, mode};
				default:   next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sysclk_select         <= SEL_RESET;
			fast_osc_idle_keep    <= 1'b0;
			slow_osc_idle_keep    <= 1'b0;
			fast_osc_enable       <= FAST_EN_RESET;
			fast_osc_stable_flag  <= 1'b0;
			settle_cnt            <= 16'(SETTLE_CYCLES);
			watchdog_timeout_flag <= 1'b0;
			powerdown_flag        <= 1'b0;
			mode                  <= MODE_NORMAL;
			active_sel            <= SEL_RESET;
			rdata                 <= 8'h00;
		end else begin
			sysclk_select         <= next_sysclk_select;
			fast_osc_idle_keep    <= next_fast_osc_idle_keep;
			slow_osc_idle_keep    <= next_slow_osc_idle_keep;
			fast_osc_enable       <= next_fast_osc_enable;
			fast_osc_stable_flag  <= next_fast_osc_stable_flag;
			settle_cnt            <= next_settle_cnt;
			watchdog_timeout_flag <= next_watchdog_timeout_flag;
			powerdown_flag        <= next_powerdown_flag;
			mode                  <= next_mode;
			active_sel            <= next_active_sel;
			rdata                 <= next_rdata;
		end
	end

	// clock gating outputs, all registered
	logic sub_sel;
	logic n_fast_clk;
	logic n_sub_clk;
	logic n_sys_clk;
	logic n_slow_osc;
	logic n_fast_osc;
	// follows the select being registered, so sysclk gate and source flag agree
	assign sub_sel = (next_active_sel == SEL_SUB);
	always_comb begin
		n_fast_clk = 1'b1;
		n_sub_clk  = 1'b1;
		n_sys_clk  = 1'b1;
		n_slow_osc = 1'b1;
		// fast osc follows enable in slow
		n_fast_osc = fast_osc_enable || !sub_sel;
		case (next_mode)
			MODE_NORMAL: n_fast_osc = 1'b1;
			MODE_SLOW:   n_fast_clk = n_fast_osc;
			MODE_SLEEP: begin
				n_fast_osc = 1'b0;
				n_fast_clk = 1'b0;
				n_sub_clk  = 1'b0;
				n_sys_clk  = 1'b0;
				n_slow_osc = i_wdt_enable;
			end
			MODE_IDLE_SUB: begin
				n_fast_osc = 1'b0;
				n_fast_clk = 1'b0;
				n_sys_clk  = sub_sel;
			end
			MODE_IDLE_BOTH: n_fast_osc = 1'b1;
			MODE_IDLE_FAST: begin
				n_fast_osc = 1'b1;
				n_sub_clk  = 1'b0;
				n_sys_clk  = !sub_sel;
			end
			default: n_fast_osc = 1'b1;
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_fast_osc_en  <= 1'b1;
			o_slow_osc_en  <= 1'b1;
			o_fast_clk_en  <= 1'b1;
			o_sub_clk_en   <= 1'b1;
			o_sys_clk_en   <= 1'b1;
			o_cpu_run      <= 1'b1;
			o_sys_src_sub  <= 1'b0;
			o_fast_div_sel <= SEL_RESET;
			o_wdt_clk_en   <= 1'b1;
			o_tb_clk_en    <= 1'b1;
			o_mode         <= 3'h0;
		end else begin
			o_fast_osc_en  <= n_fast_osc;
			o_slow_osc_en  <= n_slow_osc;
			o_fast_clk_en  <= n_fast_clk;
			o_sub_clk_en   <= n_sub_clk && n_slow_osc;
			o_sys_clk_en   <= n_sys_clk;
			o_cpu_run      <= (next_mode == MODE_NORMAL) || (next_mode == MODE_SLOW);
			o_sys_src_sub  <= (next_active_sel == SEL_SUB);
			o_fast_div_sel <= next_active_sel;
			o_wdt_clk_en   <= n_slow_osc;
			o_tb_clk_en    <= n_sub_clk || n_fast_clk;
			o_mode         <= next_mode;
		end
	end
	assign o_rdata = rdata;
endmodule : scpm_ctrl

`default_nettype wire

// file: scpm_ctrl_props.sv
// port assertions for the clock and power mode controller
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module scpm_ctrl_props
	import scpm_pkg::*;
(
	input wire logic       i_clock,
	input wire logic       i_rst,
	input wire logic [3:0] i_addr,
	input wire logic       i_rd,
	input wire logic       i_halt,
	input wire logic       i_wdt_clear,
	input wire logic       i_wdt_timeout,
	input wire logic [7:0] o_rdata,
	input wire logic       o_slow_osc_en,
	input wire logic       o_fast_clk_en,
	input wire logic       o_sub_clk_en,
	input wire logic       o_sys_clk_en,
	input wire logic       o_cpu_run,
	input wire logic       o_sys_src_sub,
	input wire logic [2:0] o_mode
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// read strobe without a flag event in the same cycle
	sequence rd_st;
		i_rd && i_addr == ADDR_STATUS && !i_halt && !i_wdt_clear && !i_wdt_timeout;
	endsequence
	// one cycle without a flag event between the event and the read strobe
	sequence quiet_st;
		!i_halt && !i_wdt_clear && !i_wdt_timeout;
	endsequence
	halt_stop_a: assert property (i_halt && o_cpu_run |-> ##[1:2] !o_cpu_run)
		else $error("cpu still runs after halt");
	halt_flags_a: assert property (i_halt && !i_wdt_timeout ##1 quiet_st ##1 rd_st
		|=> o_rdata[5:4] == 2'b01)
		else $error("flags wrong after halt");
	clr_flags_a: assert property (i_wdt_clear && !i_halt && !i_wdt_timeout ##1 quiet_st
		##1 rd_st |=> o_rdata[5:4] == 2'b00)
		else $error("flags wrong after clear");
	normal_run_a: assert property (o_mode == MODE_NORMAL
		|-> o_fast_clk_en && o_sub_clk_en && o_slow_osc_en)
		else $error("clock off in normal mode");
	sleep_off_a: assert property (o_mode == MODE_SLEEP
		|-> !(o_sys_clk_en || o_fast_clk_en || o_sub_clk_en))
		else $error("clock on in sleep");
	idle_sub_a: assert property (o_mode == MODE_IDLE_SUB
		|-> !o_fast_clk_en && o_sub_clk_en && o_sys_clk_en == o_sys_src_sub)
		else $error("idle sub clocks wrong");
	idle_both_a: assert property (o_mode == MODE_IDLE_BOTH
		|-> o_fast_clk_en && o_sub_clk_en && o_slow_osc_en && o_sys_clk_en)
		else $error("idle both clocks wrong");
	idle_fast_a: assert property (o_mode == MODE_IDLE_FAST
		|-> o_fast_clk_en && !o_sub_clk_en && o_sys_clk_en != o_sys_src_sub)
		else $error("idle fast clocks wrong");
	cover property (o_mode == MODE_SLEEP);
	cover property (o_mode == MODE_IDLE_SUB && o_sys_clk_en);
	cover property (o_mode == MODE_IDLE_FAST && o_sys_clk_en);
endmodule : scpm_ctrl_props
bind scpm_ctrl scpm_ctrl_props u_props (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
	.i_rd(i_rd), .i_halt(i_halt), .i_wdt_clear(i_wdt_clear), .i_wdt_timeout(i_wdt_timeout),
	.o_rdata(o_rdata), .o_slow_osc_en(o_slow_osc_en), .o_fast_clk_en(o_fast_clk_en),
	.o_sub_clk_en(o_sub_clk_en), .o_sys_clk_en(o_sys_clk_en), .o_cpu_run(o_cpu_run),
	.o_sys_src_sub(o_sys_src_sub), .o_mode(o_mode));
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the clock and power mode controller
// assumes the plain register port and one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import scpm_pkg::*;
;
	logic       i_clock = 1'b0;
	logic       i_rst   = 1'b1;
	logic [3:0] i_addr  = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic       i_wr    = 1'b0;
	logic       i_rd    = 1'b0;
	logic [3:0] pls     = 4'h0;
	logic       wdt_en  = 1'b0;
	logic [7:0] cyc     = 8'h00;
	logic [7:0] rdata;
	logic       fosc, sosc, fclk, sclk, sys, cpu, sub, wclk, tclk;
	logic [2:0] dsel, mode;
	int         fail_count = 0, num_checks = 0, s, k, r, sys_e, m_to = 0, m_pdf = 0;
	always #5 i_clock = ~i_clock;
	// tick inputs come from a counter so they change only on the edge
	// a disabled oscillator stops its ticks, as the real one would
	always @(posedge i_clock) cyc <= cyc + 8'h01;
	scpm_ctrl #(.SETTLE_CYCLES(4)) dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_halt(pls[0]), .i_wdt_clear(pls[1]),
		.i_wdt_timeout(pls[2]), .i_wdt_enable(wdt_en), .i_wake(pls[3]),
		.i_fast_tick(cyc[2] & fosc), .i_slow_tick(cyc[7] & sosc), .o_rdata(rdata),
		.o_fast_osc_en(fosc), .o_slow_osc_en(sosc),
		.o_fast_clk_en(fclk), .o_sub_clk_en(sclk), .o_sys_clk_en(sys), .o_cpu_run(cpu),
		.o_sys_src_sub(sub), .o_fast_div_sel(dsel), .o_wdt_clk_en(wclk), .o_tb_clk_en(tclk),
		.o_mode(mode));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// status flags as the model holds them
	function automatic logic [7:0] exp_status();
		exp_status = {2'b00, m_to[0], m_pdf[0], 4'h0};
	endfunction : exp_status
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e,
		input logic [7:0] m);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk(nm, e & m, rdata & m);
	endtask : rd_chk
	// bit 0 halt, 1 watchdog clear, 2 timeout, 3 wake
	task automatic pulse(input int b);
		@(posedge i_clock);
		pls[b] <= 1'b1;
		if (b == 0) m_pdf = 1;
		if (b == 0 || b == 1) m_to = 0;
		if (b == 1) m_pdf = 0;
		if (b == 2) m_to = 1;
		@(posedge i_clock);
		pls <= 4'h0;
	endtask : pulse
	task automatic settle(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : settle
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	// long enough for every sub-clock switch, far under the cycle budget
	initial begin
		#500000;
		fail_count++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'hc672eda3));
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		rd_chk("status", ADDR_STATUS, exp_status(), 8'h30);
		rd_chk("sysclk", ADDR_SYSCLK, 8'h00, 8'hff);
		rd_chk("fastosc", ADDR_FASTOSC, 8'h01, 8'h01);
		rd_chk("unmapped", 4'h9, 8'h00, 8'hff);
		chk("wdt tb clk", 8'h03, {6'h00, wclk, tclk});
		$display("test reset done");
		pulse(2);
		rd_chk("status", ADDR_STATUS, exp_status(), 8'h30);
		// flags are read-only, the write must leave them alone
		wr(ADDR_STATUS, 8'hff);
		rd_chk("status", ADDR_STATUS, exp_status(), 8'h30);
		pulse(1);
		rd_chk("status", ADDR_STATUS, exp_status(), 8'h30);
		$display("test flags done");
		for (s = 0; s < 8; s++) begin
			r = $urandom;
			wr(ADDR_SYSCLK, {s[2:0], r[4:0]});
			for (int n = 0; n < 2000 && dsel !== s[2:0]; n++) @(posedge i_clock);
			settle(2);
			chk("div sel", 8'(s), 8'(dsel));
			chk("src sub", 8'(s == 7), 8'(sub));
			chk("mode", (s == 7) ? 8'(MODE_SLOW) : 8'(MODE_NORMAL), 8'(mode));
			rd_chk("sysclk", ADDR_SYSCLK, {s[2:0], 3'b000, r[1:0]}, 8'hff);
		end
		wr(ADDR_FASTOSC, 8'h00);
		settle(2);
		chk("fast osc", 8'h00, 8'(fosc));
		rd_chk("fastosc", ADDR_FASTOSC, 8'h00, 8'h03);
		wr(ADDR_FASTOSC, 8'h01);
		rd_chk("fastosc", ADDR_FASTOSC, 8'h01, 8'h03);
		settle(100);
		rd_chk("fastosc", ADDR_FASTOSC, 8'h03, 8'h03);
		$display("test select done");
		for (int i = 0; i < 8; i++) begin
			s = (i < 4) ? 0 : 7;
			k = i % 4;
			r = $urandom;
			@(posedge i_clock);
			wdt_en <= r[0];
			wr(ADDR_SYSCLK, {s[2:0], 3'b000, k[1:0]});
			for (int n = 0; n < 2000 && dsel !== s[2:0]; n++) @(posedge i_clock);
			pulse(2);
			pulse(0);
			// read right after the halt, so the flag assertion sees it
			rd_chk("status", ADDR_STATUS, exp_status(), 8'h30);
			settle(2);
			sys_e = (k == 3) || (k == 1 && s == 7) || (k == 2 && s != 7);
			chk("halt mode", 8'(k == 0 ? 2 : k == 1 ? 3 : k == 3 ? 4 : 5), 8'(mode));
			chk("clocks", 8'({sys_e[0], k[1:0]}),
				{4'h0, cpu, sys, fclk, sclk});
			chk("fast osc", 8'(k[1]), 8'(fosc));
			chk("wdt tb clk", 8'({k != 0 || wdt_en, k != 0}), {6'h00, wclk, tclk});
			if (k == 0) chk("slow osc", 8'(wdt_en), 8'(sosc));
			pulse(3);
			settle(3);
			chk("wake mode", 8'(s == 7), 8'(mode));
			pulse(1);
			rd_chk("status", ADDR_STATUS, exp_status(), 8'h30);
		end
		$display("test modes done");
		// mid-run reset from slow mode with a raised timeout flag
		pulse(2);
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		m_to = 0;
		m_pdf = 0;
		rd_chk("status", ADDR_STATUS, exp_status(), 8'h30);
		rd_chk("sysclk", ADDR_SYSCLK, 8'h00, 8'hff);
		rd_chk("fastosc", ADDR_FASTOSC, 8'h01, 8'h01);
		chk("div sel", 8'h00, 8'(dsel));
		chk("mode", 8'(MODE_NORMAL), 8'(mode));
		$display("test second reset done");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
